// *** src/oaf_pkg.sv ***
// package: shared constants and types of the oversampling averaging filter
package oaf_pkg;

  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_CH      = 8;
  localparam int unsigned SAMPLE_W    = 16;
  localparam int unsigned RATIO_W     = 4;   // log2 of ratio, 0..8
  localparam int unsigned ACC_W       = SAMPLE_W + 9;

  // ----------------------------------------------------------------------
  // register map of the device end
  // ----------------------------------------------------------------------
  localparam logic [5:0] DEV_CONFIG_ADDR  = 6'h02;
  localparam logic [5:0] DEV_RATIO_ADDR   = 6'h08;
  localparam int unsigned CFG_EXT_CLK_BIT = 5;
  localparam logic [7:0] DEV_CONFIG_RST   = 8'h00;
  localparam logic [7:0] DEV_RATIO_RST    = 8'h00;
  localparam int unsigned RATIO_LSB       = 0;   // ratio code bits [3:0]
  localparam int unsigned PAD_LSB         = 4;   // padding bits [7:4]
  localparam logic [2:0] PINS_SOFTWARE    = 3'h7;
  localparam logic [3:0] MAX_SW_RATIO     = 4'h8;

  // ----------------------------------------------------------------------
  // timing (100 MHz clock)
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned CONV_NS          = 200;   // one conversion
  localparam int unsigned CONV_CYC         = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TICK_NS          = 500;   // internal tick period
  localparam int unsigned TICK_CYC         = (TICK_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PAD_STEP_NS      = 100;   // per padding unit
  localparam int unsigned PAD_STEP_CYC     = (PAD_STEP_NS * CLK_MHZ) / 1000;
  localparam int unsigned PRESET_MIN_NS    = 55;
  localparam int unsigned PRESET_MIN_CYC   = (PRESET_MIN_NS * CLK_MHZ + 999)
                                             / 1000;
  localparam int unsigned PRESET_MAX_NS    = 2000;
  localparam int unsigned PRESET_MAX_CYC   = (PRESET_MAX_NS * CLK_MHZ) / 1000;
  localparam int unsigned FRESET_MIN_NS    = 3200;
  localparam int unsigned FRESET_MIN_CYC   = (FRESET_MIN_NS * CLK_MHZ + 999)
                                             / 1000;

  // ----------------------------------------------------------------------
  // host register map (avalon word addresses, byte = 4 x index)
  // ----------------------------------------------------------------------
  localparam logic [3:0] HOST_CTRL_IDX    = 4'h0;  // rw: start, resets, period
  localparam logic [3:0] HOST_STATUS_IDX  = 4'h1;  // ro: busy, done
  localparam logic [3:0] HOST_CFGWR_IDX   = 4'h2;  // wo: device reg write
  localparam logic [3:0] HOST_PINS_IDX    = 4'h3;  // rw: ratio pins
  localparam logic [3:0] HOST_DATA_IDX    = 4'h8;  // ro: results 8..15
  localparam int unsigned CTRL_RUN_BIT    = 0;
  localparam int unsigned CTRL_PRST_BIT   = 1;
  localparam int unsigned CTRL_FRST_BIT   = 2;
  localparam int unsigned CTRL_PER_LSB    = 16;
  localparam logic [15:0] HOST_PER_RST    = 16'h0100;
  localparam logic [31:0] HOST_UNMAPPED   = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // burst state
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    OAF_IDLE = 4'b0001,
    OAF_CONV = 4'b0010,
    OAF_WAIT = 4'b0100,
    OAF_DONE = 4'b1000
  } oaf_state_t;

endpackage : oaf_pkg

// *** src/oaf_link_if.sv ***
// interface: pins between the host controller and the converter filter
`timescale 1ns/1ps
`default_nettype none
interface oaf_link_if;
  logic                          conversion_start;
  logic                          reset_pin;
  logic [2:0]                    ratio_select_pins;
  logic                          busy;
  logic                          reg_wr;
  logic [5:0]                    reg_addr;
  logic [7:0]                    reg_wdata;
  logic [oaf_pkg::NUM_CH*oaf_pkg::SAMPLE_W-1:0] result;

  modport dev (
    input  conversion_start, reset_pin, ratio_select_pins,
    input  reg_wr, reg_addr, reg_wdata,
    output busy, result
  );
  modport host (
    output conversion_start, reset_pin, ratio_select_pins,
    output reg_wr, reg_addr, reg_wdata,
    input  busy, result
  );
endinterface : oaf_link_if
`default_nettype wire

// *** src/oaf_device.sv ***
// module: device end, burst sequencer and averaging filter
// Summary of operation
// - hardware mode latches ratio pins at busy fall
// - all pins high: ratio from ratio register
// - software mode adds ratios 128 and 256
// - first sample on start edge, rest on tick
// - average N samples, output only the average
// - busy stays high through whole burst
// - host slows start rate for longer conversion
// - host may read results while busy high
// - idle after last tick until next start
// - padding slows tick to spread samples evenly
// - config bit 5: start pin clocks samples
// - external clock: one average per N edges
// - external clock identical for both interfaces
// - short reset aborts burst and clears results
// - host shares one start signal among devices
// - pins decode binary: 0 none, 1..6 ratio, 7 sw
// - host holds partial reset 55 ns to 2 us
`timescale 1ns/1ps
`default_nettype none
module oaf_device #(
  parameter int unsigned TICK_CYCLES = oaf_pkg::TICK_CYC
) (
  input  wire logic                                   clk_i,
  input  wire logic                                   reset_i,
  oaf_link_if.dev                                     link,
  input  wire logic [oaf_pkg::NUM_CH*oaf_pkg::SAMPLE_W-1:0] sample_i,
  input  wire logic                                   parallel_sel_i,
  output logic                                        sample_strobe_o
);

  localparam int unsigned CW = 16;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    oaf_pkg::oaf_state_t                       st;
    logic [7:0]                                cfg;
    logic [7:0]                                ratio_reg;
    logic [2:0]                                pins_lat;
    logic                                      sw_mode;
    logic [oaf_pkg::RATIO_W-1:0]               k;      // burst log2 ratio
    logic [8:0]                                nsamp;  // samples taken
    logic [CW-1:0]                             cnt;
    logic                                      cs_prev;
    logic                                      rst_prev;
    logic [CW-1:0]                             rst_len;
    logic                                      busy;
    logic                                      strobe;
    logic [oaf_pkg::NUM_CH*oaf_pkg::ACC_W-1:0] acc;
    logic [oaf_pkg::NUM_CH*oaf_pkg::SAMPLE_W-1:0] result;
  } oaf_dev_state_t;

  oaf_dev_state_t s_q;
  oaf_dev_state_t s_d;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // pin code to log2 ratio, binary
  function automatic logic [oaf_pkg::RATIO_W-1:0] oaf_pin_ratio(
      input logic [2:0] p);
    oaf_pin_ratio = {1'b0, p};
  endfunction : oaf_pin_ratio

  // rounded, saturated average of one accumulator
  function automatic logic [oaf_pkg::SAMPLE_W-1:0] oaf_avg(
      input logic signed [oaf_pkg::ACC_W-1:0] a,
      input logic [oaf_pkg::RATIO_W-1:0]      k);
    logic signed [oaf_pkg::ACC_W:0] r;
    r = '0;
    if (k == '0) begin
      r = {a[oaf_pkg::ACC_W-1], a};
    end else begin
      // signed sum so the arithmetic shift keeps the sign of the average
      r = ($signed({a[oaf_pkg::ACC_W-1], a}) +
           $signed((oaf_pkg::ACC_W+1)'(1) << (k - 1'b1))) >>> k;
    end
    if (r > (oaf_pkg::ACC_W+1)'(32767)) begin
      oaf_avg = 16'h7FFF;
    end else if (r < -(oaf_pkg::ACC_W+1)'(32768)) begin
      oaf_avg = 16'h8000;
    end else begin
      oaf_avg = r[oaf_pkg::SAMPLE_W-1:0];
    end
  endfunction : oaf_avg

  logic                        cs_rise;
  logic                        ext_clk;
  logic [oaf_pkg::RATIO_W-1:0] cur_k;
  logic [3:0]                  reg_k;
  logic [CW-1:0]               tick_len;

  // ratio selection and tick length
  always_comb begin
    cs_rise  = link.conversion_start & ~s_q.cs_prev;
    reg_k    = s_q.ratio_reg[oaf_pkg::RATIO_LSB +: 4];
    // clamp register codes above 256 to 256
    if (reg_k > oaf_pkg::MAX_SW_RATIO) begin
      reg_k = oaf_pkg::MAX_SW_RATIO;
    end
    // register ratio when all pins high, else latched pins
    cur_k    = s_q.sw_mode ? reg_k : oaf_pin_ratio(s_q.pins_lat);
    // external clock only in software mode with averaging on
    ext_clk  = s_q.sw_mode & s_q.cfg[oaf_pkg::CFG_EXT_CLK_BIT] & (cur_k != '0);
    // padding lengthens the tick period
    tick_len = CW'(TICK_CYCLES) + CW'(oaf_pkg::PAD_STEP_CYC) *
               CW'(s_q.sw_mode ? s_q.ratio_reg[oaf_pkg::PAD_LSB +: 4] : 4'h0);
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d          = s_q;
    s_d.cs_prev  = link.conversion_start;
    s_d.rst_prev = link.reset_pin;
    s_d.strobe   = 1'b0;
    if (link.reset_pin) begin
      s_d.rst_len = (s_q.rst_len == '1) ? s_q.rst_len : s_q.rst_len + 1'b1;
    end else begin
      s_d.rst_len = '0;
    end
    if (link.reg_wr && s_q.sw_mode) begin
      if (link.reg_addr == oaf_pkg::DEV_CONFIG_ADDR) begin
        s_d.cfg = link.reg_wdata;
      end
      if (link.reg_addr == oaf_pkg::DEV_RATIO_ADDR) begin
        s_d.ratio_reg = link.reg_wdata;
      end
    end
    unique case (s_q.st)
      oaf_pkg::OAF_IDLE: begin
        // first sample on the start edge
        if (cs_rise) begin
          s_d.k      = cur_k;
          s_d.acc    = '0;
          s_d.nsamp  = '0;
          s_d.cnt    = CW'(oaf_pkg::CONV_CYC);
          s_d.busy   = 1'b1;
          s_d.strobe = 1'b1;
          s_d.st     = oaf_pkg::OAF_CONV;
        end
      end
      oaf_pkg::OAF_CONV: begin
        // accumulate the sample taken at the strobe
        if (s_q.strobe) begin
          for (int c = 0; c < int'(oaf_pkg::NUM_CH); c++) begin
            s_d.acc[c*oaf_pkg::ACC_W +: oaf_pkg::ACC_W] =
              s_q.acc[c*oaf_pkg::ACC_W +: oaf_pkg::ACC_W] +
              {{(oaf_pkg::ACC_W-oaf_pkg::SAMPLE_W)
                {sample_i[c*oaf_pkg::SAMPLE_W+oaf_pkg::SAMPLE_W-1]}},
               sample_i[c*oaf_pkg::SAMPLE_W +: oaf_pkg::SAMPLE_W]};
          end
          s_d.nsamp = s_q.nsamp + 1'b1;
        end
        if (s_q.cnt > CW'(1)) begin
          s_d.cnt = s_q.cnt - 1'b1;
        end else if (s_q.nsamp == (9'h001 << s_q.k)) begin
          s_d.st = oaf_pkg::OAF_DONE;
        end else begin
          s_d.st  = oaf_pkg::OAF_WAIT;
          s_d.cnt = tick_len - CW'(oaf_pkg::CONV_CYC);
        end
      end
      oaf_pkg::OAF_WAIT: begin
        // next sample from start pin or internal tick
        if (ext_clk ? cs_rise : (s_q.cnt <= CW'(1))) begin
          s_d.cnt    = CW'(oaf_pkg::CONV_CYC);
          s_d.strobe = 1'b1;
          s_d.st     = oaf_pkg::OAF_CONV;
        end else if (!ext_clk) begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      oaf_pkg::OAF_DONE: begin
        // busy falls with the averaged result
        for (int c = 0; c < int'(oaf_pkg::NUM_CH); c++) begin
          s_d.result[c*oaf_pkg::SAMPLE_W +: oaf_pkg::SAMPLE_W] =
            oaf_avg(s_q.acc[c*oaf_pkg::ACC_W +: oaf_pkg::ACC_W], s_q.k);
        end
        s_d.busy = 1'b0;
        s_d.st   = oaf_pkg::OAF_IDLE;
        // pins latched at busy fall in hardware mode
        s_d.pins_lat = link.ratio_select_pins;
      end
      default: s_d.st = oaf_pkg::OAF_IDLE;
    endcase
    // reset pin released: short pulse is partial, long is full
    if (s_q.rst_prev && !link.reset_pin) begin
      // abort burst and empty results
      s_d.st     = oaf_pkg::OAF_IDLE;
      s_d.busy   = 1'b0;
      s_d.strobe = 1'b0;
      s_d.acc    = '0;
      s_d.result = '0;
      if (s_q.rst_len >= CW'(oaf_pkg::FRESET_MIN_CYC)) begin
        // full reset re-latches pins and mode
        s_d.pins_lat  = link.ratio_select_pins;
        s_d.sw_mode   = (link.ratio_select_pins == oaf_pkg::PINS_SOFTWARE);
        s_d.cfg       = oaf_pkg::DEV_CONFIG_RST;
        s_d.ratio_reg = oaf_pkg::DEV_RATIO_RST;
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers; pins and mode caught on the first cycle after reset
  // ----------------------------------------------------------------------
  logic init_q;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q        <= '0;
      s_q.st     <= oaf_pkg::OAF_IDLE;
      s_q.cfg    <= oaf_pkg::DEV_CONFIG_RST;
      s_q.ratio_reg <= oaf_pkg::DEV_RATIO_RST;
      init_q     <= 1'b1;
    end else begin
      s_q    <= s_d;
      init_q <= 1'b0;
      if (init_q) begin
        s_q.pins_lat <= link.ratio_select_pins;
        s_q.sw_mode  <= (link.ratio_select_pins == oaf_pkg::PINS_SOFTWARE);
      end
    end
  end

  // outputs; results readable during busy
  assign link.busy       = s_q.busy;
  assign link.result     = s_q.result;
  assign sample_strobe_o = s_q.strobe;

  logic unused_par;
  assign unused_par = parallel_sel_i;

endmodule : oaf_device
`default_nettype wire

// *** src/oaf_host.sv ***
// module: host end, avalon slave driving start, reset and reading results
`timescale 1ns/1ps
`default_nettype none
module oaf_host (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  oaf_link_if.host         link,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        run;
    logic [15:0] period;
    logic [15:0] pcnt;
    logic        cs;
    logic [15:0] rcnt;
    logic        rst;
    logic [2:0]  pins;
    logic        wr;
    logic [5:0]  waddr;
    logic [7:0]  wdata;
    logic        done;
    logic        busy_prev;
    logic        ack;
    logic [31:0] rdata;
  } oaf_host_state_t;

  oaf_host_state_t s_q;
  oaf_host_state_t s_d;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d           = s_q;
    s_d.wr        = 1'b0;
    s_d.ack       = 1'b0;
    s_d.busy_prev = link.busy;
    // one shared start wave at the programmed rate
    if (s_q.run) begin
      if (s_q.pcnt == '0) begin
        s_d.pcnt = s_q.period;
        s_d.cs   = 1'b1;
      end else begin
        s_d.pcnt = s_q.pcnt - 1'b1;
        if (s_q.pcnt == (s_q.period >> 1)) begin
          s_d.cs = 1'b0;
        end
      end
    end else begin
      s_d.cs   = 1'b0;
      s_d.pcnt = '0;
    end
    // reset pulse countdown
    if (s_q.rcnt != '0) begin
      s_d.rcnt = s_q.rcnt - 1'b1;
    end else begin
      s_d.rst = 1'b0;
    end
    // done flag: set wins over clear
    if (s_q.busy_prev && !link.busy) begin
      s_d.done = 1'b1;
    end
    if ((avs_read || avs_write) && !s_q.ack) begin
      s_d.ack = 1'b1;
      if (avs_write) begin
        unique case (avs_address)
          oaf_pkg::HOST_CTRL_IDX: begin
            s_d.run    = avs_writedata[oaf_pkg::CTRL_RUN_BIT];
            s_d.period = avs_writedata[oaf_pkg::CTRL_PER_LSB +: 16];
            if (avs_writedata[oaf_pkg::CTRL_PRST_BIT]) begin
              s_d.rst  = 1'b1;
              s_d.rcnt = 16'(oaf_pkg::PRESET_MIN_CYC);
            end else if (avs_writedata[oaf_pkg::CTRL_FRST_BIT]) begin
              s_d.rst  = 1'b1;
              s_d.rcnt = 16'(oaf_pkg::FRESET_MIN_CYC);
            end
          end
          oaf_pkg::HOST_CFGWR_IDX: begin
            s_d.wr    = 1'b1;
            s_d.waddr = avs_writedata[13:8];
            s_d.wdata = avs_writedata[7:0];
          end
          oaf_pkg::HOST_PINS_IDX: s_d.pins = avs_writedata[2:0];
          default: ;
        endcase
      end else begin
        // results readable even while busy
        if (avs_address >= oaf_pkg::HOST_DATA_IDX) begin
          s_d.rdata = {16'h0000,
            link.result[avs_address[2:0]*oaf_pkg::SAMPLE_W +: 16]};
        end else if (avs_address == oaf_pkg::HOST_STATUS_IDX) begin
          s_d.rdata = {30'h0000_0000, s_q.done, link.busy};
          s_d.done  = s_q.busy_prev && !link.busy;
        end else if (avs_address == oaf_pkg::HOST_CTRL_IDX) begin
          s_d.rdata = {s_q.period, 13'h0000, 2'h0, s_q.run};
        end else if (avs_address == oaf_pkg::HOST_PINS_IDX) begin
          s_d.rdata = {29'h0000_0000, s_q.pins};
        end else begin
          s_d.rdata = oaf_pkg::HOST_UNMAPPED;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q        <= '0;
      s_q.period <= oaf_pkg::HOST_PER_RST;
      s_q.pins   <= oaf_pkg::PINS_SOFTWARE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign avs_waitrequest        = (avs_read | avs_write) & ~s_q.ack;
  assign avs_readdata           = s_q.rdata;
  assign link.conversion_start  = s_q.cs;
  assign link.reset_pin         = s_q.rst;
  assign link.ratio_select_pins = s_q.pins;
  assign link.reg_wr            = s_q.wr;
  assign link.reg_addr          = s_q.waddr;
  assign link.reg_wdata         = s_q.wdata;

endmodule : oaf_host
`default_nettype wire

// *** verification/oaf_link_chk.sv ***
// checker: timing relations on the link between host end and device end
`timescale 1ns/1ps
`default_nettype none
module oaf_link_chk (
  input wire logic         clk_i,
  input wire logic         reset_i,
  input wire logic         conversion_start,
  input wire logic         reset_pin,
  input wire logic [2:0]   ratio_select_pins,
  input wire logic         busy,
  input wire logic         reg_wr,
  input wire logic [5:0]   reg_addr,
  input wire logic [7:0]   reg_wdata,
  input wire logic [127:0] result
);
  // ------------------------------------------------------------------
  // helper state
  // ------------------------------------------------------------------
  typedef struct packed { logic [15:0] len; logic [1:0] rp; } oaf_chk_t;
  oaf_chk_t st_q;
  oaf_chk_t st_d;
  logic     rp_any;
  // busy-high cycle count and two cycles of reset pin history
  always_comb begin
    st_d.len = busy ? st_q.len + 16'h0001 : 16'h0000;
    st_d.rp  = {st_q.rp[0], reset_pin};
  end
  always_ff @(posedge clk_i) begin
    if (reset_i)
      st_q <= {16'h0000, 2'h0};
    else
      st_q <= st_d;
  end
  assign rp_any = reset_pin | (|st_q.rp);
  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_start_rise;
    !conversion_start ##1 conversion_start;
  endsequence
  sequence s_pin_release;
    reset_pin ##1 !reset_pin;
  endsequence
  property p_start_busy; s_start_rise ##0 (!busy && !rp_any) |=> busy;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("start edge did not raise busy");
  property p_busy_cause;
    $rose(busy) |-> $past(conversion_start) && !$past(conversion_start, 2);
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy rose without a start edge");
  property p_busy_len;
    $fell(busy) && !rp_any |-> st_q.len >= oaf_pkg::CONV_CYC;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy shorter than one conversion");
  property p_result_hold; !$stable(result) |-> $fell(busy) || rp_any;
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result changed outside busy fall");
  property p_reset_abort; s_pin_release |-> ##[0:3] (!busy && ~|result);
  endproperty
  a_reset_abort: assert property (p_reset_abort)
    else $error("reset pulse did not abort and clear");
  property p_reset_quiet; reset_pin |-> !$rose(busy); endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("burst started under reset pin");
  property p_host_reset;
    $fell(reset_i) |-> ratio_select_pins == 3'h7 && !conversion_start
      && !reset_pin && !busy;
  endproperty
  a_host_reset: assert property (p_host_reset)
    else $error("link not idle in software mode after reset");
  property p_wr_pulse; reg_wr |=> !reg_wr; endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("register write strobe longer than one cycle");
endmodule : oaf_link_chk
`default_nettype wire

// *** verification/oversampling_averaging_filter_tb.sv ***
// testbench: host end and device end joined over the link, with a model
`timescale 1ns/1ps
`default_nettype none
module oversampling_averaging_filter_tb;
  // ------------------------------------------------------------------
  // signals and design
  // ------------------------------------------------------------------
  localparam int TICK = 25;
  logic         clk_i, reset_i, avs_read, avs_write, avs_waitrequest;
  logic         par_sel, strobe, busy_m, rp_m;
  logic [3:0]   avs_address;
  logic [31:0]  avs_writedata, avs_readdata, seed, q;
  logic [127:0] sample_i;
  int           n_fail, cmp_count, cyc, last, n_smp, got_n, chg, lat;
  int           k_m, pad_m, ext_m;
  int           sum [8];
  int           exp_avg [8];
  oaf_link_if lk ();
  oaf_host u_oaf_host (.clk_i(clk_i), .reset_i(reset_i), .link(lk),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  oaf_device #(.TICK_CYCLES(TICK)) u_oaf_device (.clk_i(clk_i),
    .reset_i(reset_i), .link(lk), .sample_i(sample_i),
    .parallel_sel_i(par_sel), .sample_strobe_o(strobe));
  oaf_link_chk u_oaf_link_chk (.clk_i(clk_i), .reset_i(reset_i),
    .conversion_start(lk.conversion_start), .reset_pin(lk.reset_pin),
    .ratio_select_pins(lk.ratio_select_pins), .busy(lk.busy),
    .reg_wr(lk.reg_wr), .reg_addr(lk.reg_addr), .reg_wdata(lk.reg_wdata),
    .result(lk.result));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t %s: got %0h exp %0h", $time, m, got, exp);
    end
  endtask : cmp
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  // one avalon transfer, released after the edge that sees waitrequest low
  task automatic av(input logic wr, input logic [3:0] a,
                    input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clk_i);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (t >= 50) cmp(32'h0, 32'h1, "bus answer missing");
  endtask : av
  task automatic rd(input logic [3:0] a);
    av(1'b0, a, 32'h0);
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    av(1'b1, a, d);
  endtask : wr
  task automatic results;
    for (int c = 0; c < 8; c++) begin
      rd(4'h8 + 4'(c));
      cmp(q[15:0], exp_avg[c][15:0], "channel result");
    end
  endtask : results
  // start conversions at the given period and wait for busy
  task automatic go(input logic [15:0] per);
    int t;
    t = 0;
    wr(4'h0, {per, 16'h0001});
    while (lk.busy !== 1'b1 && t < 9000) begin
      @(negedge clk_i);
      t++;
    end
    cmp(lk.busy, 1'b1, "busy after start");
  endtask : go
  task automatic burst(input int k, input int pad, input int ext);
    int t;
    logic [15:0] per;
    k_m = k;
    pad_m = pad;
    ext_m = ext;
    per = ext ? 16'h0028 : 16'((1 << k) * (TICK + 10 * pad) + 200);
    go(per);
    rd(4'h8);
    cmp(q[15:0], exp_avg[0][15:0], "result while busy");
    t = 0;
    while (lk.busy !== 1'b0 && t < 20000) begin
      @(negedge clk_i);
      t++;
    end
    cmp(lk.busy, 1'b0, "busy after burst");
    wr(4'h0, {per, 16'h0000});
    cmp(got_n, 1 << k, "samples per result");
    results();
    if (!ext) begin
      rd(4'h1);
      cmp(q[1:0], 2'b10, "done after burst");
      rd(4'h1);
      cmp(q[1:0], 2'b00, "done cleared");
    end
    $display("test ratio %0d pad %0d ext %0d ended", 1 << k, pad, ext);
  endtask : burst
  // ------------------------------------------------------------------
  // sample source, averaging model and run limit
  // ------------------------------------------------------------------
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (chg == 1)
      for (int i = 0; i < 4; i++) begin
        seed = lfsr(seed);
        sample_i[32*i +: 32] <= seed;
      end
    if (chg > 0) chg--;
    // the edge that sees the pin released still aborts the burst
    if (reset_i || lk.reset_pin || rp_m) begin
      n_smp = 0;
      sum = '{default: 0};
      exp_avg = '{default: 0};
    end else begin
      if (strobe) begin
        if (n_smp > 0 && ext_m == 0)
          cmp(cyc - last, TICK + 10 * pad_m, "spacing");
        last = cyc;
        n_smp++;
        chg = 5;
        for (int c = 0; c < 8; c++) sum[c] += $signed(sample_i[16*c +: 16]);
      end
      if (busy_m && !lk.busy) begin
        for (int c = 0; c < 8; c++)
          exp_avg[c] = (sum[c] + ((1 << k_m) >> 1)) >>> k_m;
        got_n = n_smp;
        n_smp = 0;
        sum = '{default: 0};
      end
    end
    busy_m = lk.busy;
    rp_m = lk.reset_pin;
    if (cyc == 90000) begin
      n_fail++;
      conclude();
    end
  end
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    reset_i = 1'b1;
    {avs_read, avs_write, par_sel, busy_m, rp_m} = 5'h00;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    sample_i = 128'h0;
    seed = 32'h0EF09742;
    chg = 2;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(4'h0);
    cmp(q, 32'h0100_0000, "control reset value");
    rd(4'h3);
    cmp(q, 32'h7, "pins reset value");
    wr(4'h5, 32'hFFFF_FFFF);
    rd(4'h5);
    cmp(q, 32'h0, "unmapped place");
    for (int k = 0; k <= 8; k++) begin
      wr(4'h2, 32'h0800 + ((k & 1) << 4) + k);
      burst(k, k & 1, 0);
    end
    wr(4'h2, 32'h0220);
    wr(4'h2, 32'h0802);
    par_sel <= 1'b1;
    burst(2, 0, 1);
    par_sel <= 1'b0;
    burst(2, 0, 1);
    wr(4'h2, 32'h0200);
    wr(4'h2, 32'h0806);
    k_m = 6;
    ext_m = 0;
    go(16'h2000);
    repeat (200) @(posedge clk_i);
    wr(4'h0, 32'h2000_0002);
    repeat (20) @(posedge clk_i);
    rd(4'h1);
    cmp(q[0], 1'b0, "busy after abort");
    results();
    $display("test partial reset ended");
    wr(4'h3, 32'h1);
    wr(4'h0, 32'h0100_0004);
    repeat (400) @(posedge clk_i);
    lat = 1;
    for (int p = 0; p <= 6; p++) begin
      wr(4'h3, p);
      wr(4'h2, 32'h0808);
      burst(lat, 0, 0);
      lat = p;
    end
    burst(lat, 0, 0);
    conclude();
  end
endmodule : oversampling_averaging_filter_tb
`default_nettype wire
